// File: src/rsoh_pkg.sv
// Constants, carrier types and helper functions for the regenerator section
// overhead processor. Shared by the design and by the verification side.
package rsoh_pkg;

  // Frame geometry, counted from 1 as row and column numbers.
  localparam logic [12:0] COL_FIRST       = 13'h0001;
  localparam logic [12:0] COL_FRAMING_END = 13'h0030;
  localparam logic [12:0] COL_A2_END      = 13'h0060;
  localparam logic [12:0] COL_TRACE       = 13'h0061;
  localparam logic [12:0] COL_SOH_LAST    = 13'h0090;
  localparam logic [12:0] COL_SCR_START   = 13'h0091;
  localparam logic [12:0] COL_LAST        = 13'h10E0;
  localparam logic [3:0]  ROW_FIRST       = 4'h1;
  localparam logic [3:0]  ROW_PARITY      = 4'h2;
  localparam logic [3:0]  ROW_RSOH_LAST   = 4'h3;
  localparam logic [3:0]  ROW_LAST        = 4'h9;

  // Fixed byte values.
  localparam logic [7:0] FRAMING_ONE = 8'hF6;
  localparam logic [7:0] FRAMING_TWO = 8'h28;
  localparam logic [7:0] ALL_ONES    = 8'hFF;
  localparam logic [6:0] SCR_SEED    = 7'h7F;

  // Frames a new trace byte must repeat before it is accepted.
  localparam logic [1:0] TRACE_PERSIST = 2'h3;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] REG_CTRL      = 5'h00;
  localparam logic [4:0] REG_TX_TRACE  = 5'h04;
  localparam logic [4:0] REG_EXP_TRACE = 5'h08;
  localparam logic [4:0] REG_STATUS    = 5'h0C;
  localparam logic [4:0] REG_ERR_COUNT = 5'h10;

  // Control register fields and reset value.
  localparam int CTRL_TIM_DISABLE = 0;
  localparam int CTRL_EXP_MODE    = 1;
  localparam int CTRL_MONITORED   = 2;
  localparam int CTRL_SSF_USED    = 3;
  localparam logic [3:0] CTRL_RESET      = 4'hE;
  localparam logic [7:0] TRACE_RESET     = 8'h00;

  // Status register fields.
  localparam int STAT_DEFECT     = 0;
  localparam int STAT_REPORT     = 1;
  localparam int STAT_RX_AIS     = 2;
  localparam int STAT_TX_AIS     = 3;
  localparam int STAT_ACC_LSB    = 8;

  typedef struct packed {
    logic       fs;
    logic [7:0] data;
  } rsoh_byte_t;

  typedef struct packed {
    logic [3:0]  row;
    logic [12:0] col;
  } rsoh_pos_t;

  // Position of the byte now arriving, given the previous one and the marker.
  function automatic rsoh_pos_t rsoh_advance(input rsoh_pos_t prev, input logic fs);
    rsoh_pos_t p;
    p = prev;
    if (fs)
    begin
      p.row = ROW_FIRST;
      p.col = COL_FIRST;
    end
    else if (prev.col == COL_LAST)
    begin
      p.col = COL_FIRST;
      p.row = (prev.row == ROW_LAST) ? ROW_FIRST : 4'(prev.row + 4'h1);
    end
    else
      p.col = 13'(prev.col + 13'h0001);
    return p;
  endfunction

  // One byte of the 1 + x^6 + x^7 scrambler, MSB first: {mask, next state}.
  function automatic logic [14:0] rsoh_scr_step(input logic [6:0] st);
    logic [6:0] s;
    logic [7:0] m;
    s = st;
    m = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      m[i] = s[6];
      s = {s[5:0], s[6] ^ s[5]};
    end
    return {m, s};
  endfunction

  // Row one, columns 1..144 bypass scrambling.
  function automatic logic rsoh_unscrambled(input rsoh_pos_t p);
    return (p.row == ROW_FIRST) && (p.col <= COL_SOH_LAST);
  endfunction

endpackage

// File: src/rsoh_proc.sv
// Regenerator section overhead processor for a 2.5 Gbit/s frame: transmit
// adaptation and termination source, receive termination sink.
// Assumes one co-directional link byte clock, slower than i_clock, with link
// data and markers changing away from its rising edge.
//
// Overview of operation
// RQ1 - Frame carries payload plus overhead channel bytes.
// RQ2 - Absent channel bytes may carry undefined content.
// RQ3 - Unused bypassed bytes avoid long runs.
// RQ4 - Insert configured trace into trace byte.
// RQ5 - Compute even bit-interleaved eight-bit parity.
// RQ6 - Parity of previous scrambled frame, pre-scramble.
// RQ7 - Insert framing runs into overhead.
// RQ8 - Forty-eight 0xF6 then forty-eight 0x28.
// RQ9 - Frame-synchronous scrambler, polynomial 1+x6+x7.
// RQ10 - Scrambler reset to ones at column 145.
// RQ11 - XOR with seventh stage, then free-run.
// RQ12 - Sink descrambles identically to source.
// RQ13 - Sink checks parity per bit position.
// RQ14 - Parity mismatch reports near-end block error.
// RQ15 - Recover received trace, present accepted trace.
// RQ16 - Trace mismatch defect from expected trace.
// RQ17 - All-ones and fail on fail or defect.
// RQ18 - Sink inserts all-ones after descrambling.
// RQ19 - Sink all-ones applied and removed within 250us.
// RQ20 - Mismatch report needs monitored state and defect.
// RQ21 - Source all-ones on fail within 250us.
// RQ22 - Unconnected fail input treated as false.
// RQ23 - Sink passes data, clock, marker through.
`timescale 1ns/1ps
module rsoh_proc
  import rsoh_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  // Avalon-MM slave.
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Link byte clock, shared by both directions.
  input  wire logic        i_link_clk,
  // Transmit: frame from the multiplex section side, out to the line.
  input  wire logic [7:0]  i_tx_data,
  input  wire logic        i_tx_fs,
  input  wire logic        i_tx_ssf,
  output logic [7:0]       o_tx_data,
  output logic             o_tx_fs,
  output logic             o_tx_byte_clk,
  // Receive: frame from the line, out to the adaptation side.
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_fs,
  input  wire logic        i_rx_ssf,
  output logic [7:0]       o_rx_data,
  output logic             o_rx_fs,
  output logic             o_rx_byte_clk,
  output logic             o_rx_tsf,
  output logic             o_trace_mismatch_report,
  output logic             o_near_end_block_error
);

  // Synchronisers: stage one feeds stage two only.
  logic [1:0] link_clk_meta_reg;
  logic       link_clk_dly_reg;
  rsoh_byte_t tx_in_meta_reg;
  rsoh_byte_t tx_in_reg;
  rsoh_byte_t rx_in_meta_reg;
  rsoh_byte_t rx_in_reg;
  logic [1:0] ssf_meta_reg;
  logic [1:0] ssf_sync_reg;
  logic       tick;

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      link_clk_meta_reg <= 2'h0;
      link_clk_dly_reg  <= 1'b0;
      tx_in_meta_reg    <= '0;
      tx_in_reg         <= '0;
      rx_in_meta_reg    <= '0;
      rx_in_reg         <= '0;
      ssf_meta_reg      <= 2'h0;
      ssf_sync_reg      <= 2'h0;
    end
    else
    begin
      link_clk_meta_reg <= {link_clk_meta_reg[0], i_link_clk};
      link_clk_dly_reg  <= link_clk_meta_reg[1];
      tx_in_meta_reg    <= '{fs: i_tx_fs, data: i_tx_data};
      tx_in_reg         <= tx_in_meta_reg;
      rx_in_meta_reg    <= '{fs: i_rx_fs, data: i_rx_data};
      rx_in_reg         <= rx_in_meta_reg;
      ssf_meta_reg      <= {i_rx_ssf, i_tx_ssf};
      ssf_sync_reg      <= ssf_meta_reg;
    end
  end

  // One byte is taken per rising edge of the link clock.
  assign tick = link_clk_meta_reg[1] & ~link_clk_dly_reg;

  // Software-visible configuration.
  logic [3:0] ctrl_reg;
  logic [7:0] tx_trace_reg;
  logic [7:0] exp_trace_reg;
  logic [7:0] acc_trace_reg;
  logic       defect_reg;
  logic       rx_ais_reg;
  logic       tx_ais_reg;
  logic [15:0] err_count_reg;
  logic       wait_reg;
  logic       bus_write;
  logic       bus_read;

  // A request is held for one wait cycle, then answered.
  assign bus_write = i_avs_write & ~wait_reg;
  assign bus_read  = i_avs_read & wait_reg;

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      wait_reg <= 1'b1;
    else
      wait_reg <= ~((i_avs_read | i_avs_write) & wait_reg);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      ctrl_reg      <= CTRL_RESET;
      tx_trace_reg  <= TRACE_RESET;
      exp_trace_reg <= TRACE_RESET;
    end
    else if (bus_write && i_avs_byteenable[0])
    begin
      case (i_avs_address)
        REG_CTRL:      ctrl_reg      <= i_avs_writedata[3:0];
        REG_TX_TRACE:  tx_trace_reg  <= i_avs_writedata[7:0];
        REG_EXP_TRACE: exp_trace_reg <= i_avs_writedata[7:0];
        default:       ctrl_reg      <= ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_avs_readdata <= 32'h00000000;
    else if (bus_read)
    begin
      case (i_avs_address)
        REG_CTRL:      o_avs_readdata <= {28'h0000000, ctrl_reg};
        REG_TX_TRACE:  o_avs_readdata <= {24'h000000, tx_trace_reg};
        REG_EXP_TRACE: o_avs_readdata <= {24'h000000, exp_trace_reg};
        REG_STATUS:    o_avs_readdata <= {16'h0000, acc_trace_reg, 4'h0, tx_ais_reg,
                                          rx_ais_reg, o_trace_mismatch_report, defect_reg};
        REG_ERR_COUNT: o_avs_readdata <= {16'h0000, err_count_reg};
        default:       o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  assign o_avs_waitrequest = wait_reg;

  // Transmit path.
  rsoh_pos_t  tx_pos_reg;
  rsoh_pos_t  tx_pos;
  logic [6:0] tx_scr_reg;
  logic [6:0] tx_scr_st;
  logic [14:0] tx_step;
  logic [7:0] tx_bip_acc_reg;
  logic [7:0] tx_bip_prev_reg;
  logic [7:0] tx_byte;
  logic [7:0] tx_scrambled;
  logic       tx_payload;
  logic       tx_ais;

  always_comb
  begin
    tx_pos     = rsoh_advance(tx_pos_reg, tx_in_reg.fs);
    tx_payload = (tx_pos.row > ROW_RSOH_LAST) || (tx_pos.col > COL_SOH_LAST);
    // RQ22 fail unconnected false
    tx_ais     = ssf_sync_reg[0] & ctrl_reg[CTRL_SSF_USED];
    // RQ1 payload and channels
    // RQ2 channels pass untouched
    tx_byte    = tx_in_reg.data;
    // RQ21 all-ones on fail
    if (tx_ais && tx_payload)
      tx_byte = ALL_ONES;
    if (tx_pos.row == ROW_FIRST)
    begin
      // RQ7 framing pattern insert
      // RQ8 framing byte values
      if (tx_pos.col <= COL_FRAMING_END)
        tx_byte = FRAMING_ONE;
      else if (tx_pos.col <= COL_A2_END)
        tx_byte = FRAMING_TWO;
      // RQ4 trace byte insert
      else if (tx_pos.col == COL_TRACE)
        tx_byte = tx_trace_reg;
    end
    // RQ6 parity placed pre-scramble
    if (tx_pos.row == ROW_PARITY && tx_pos.col == COL_FIRST)
      tx_byte = tx_bip_prev_reg;
    // RQ10 seed at column 145
    tx_scr_st = (tx_pos.row == ROW_FIRST && tx_pos.col == COL_SCR_START) ? SCR_SEED
                                                                        : tx_scr_reg;
    tx_step   = rsoh_scr_step(tx_scr_st);
    // RQ9 scramble at line rate
    // RQ11 XOR seventh stage
    tx_scrambled = rsoh_unscrambled(tx_pos) ? tx_byte : (tx_byte ^ tx_step[14:7]);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      tx_pos_reg      <= '{row: ROW_FIRST, col: COL_FIRST};
      tx_scr_reg      <= SCR_SEED;
      tx_bip_acc_reg  <= 8'h00;
      tx_bip_prev_reg <= 8'h00;
      o_tx_data       <= 8'h00;
      o_tx_fs         <= 1'b0;
      tx_ais_reg      <= 1'b0;
    end
    else
    begin
      tx_ais_reg <= tx_ais;
      if (tick)
      begin
        tx_pos_reg <= tx_pos;
        // RQ11 free-run rest of frame
        if (!rsoh_unscrambled(tx_pos))
          tx_scr_reg <= tx_step[6:0];
        // RQ5 even interleaved parity
        // RQ6 over scrambled bytes
        if (tx_in_reg.fs)
        begin
          tx_bip_prev_reg <= tx_bip_acc_reg;
          tx_bip_acc_reg  <= tx_scrambled;
        end
        else
          tx_bip_acc_reg <= tx_bip_acc_reg ^ tx_scrambled;
        o_tx_data <= tx_scrambled;
        o_tx_fs   <= tx_in_reg.fs;
      end
    end
  end

  // Receive path.
  rsoh_pos_t  rx_pos_reg;
  rsoh_pos_t  rx_pos;
  logic [6:0] rx_scr_reg;
  logic [6:0] rx_scr_st;
  logic [14:0] rx_step;
  logic [7:0] rx_bip_acc_reg;
  logic [7:0] rx_bip_prev_reg;
  logic [7:0] rx_plain;
  logic [7:0] trace_cand_reg;
  logic [1:0] trace_cnt_reg;
  logic       parity_bad;
  logic       rx_ais;

  always_comb
  begin
    rx_pos    = rsoh_advance(rx_pos_reg, rx_in_reg.fs);
    rx_scr_st = (rx_pos.row == ROW_FIRST && rx_pos.col == COL_SCR_START) ? SCR_SEED
                                                                        : rx_scr_reg;
    rx_step   = rsoh_scr_step(rx_scr_st);
    // RQ12 identical descrambler
    rx_plain  = rsoh_unscrambled(rx_pos) ? rx_in_reg.data
                                         : (rx_in_reg.data ^ rx_step[14:7]);
    // RQ13 compare each bit position
    parity_bad = (rx_pos.row == ROW_PARITY) && (rx_pos.col == COL_FIRST)
                 && (rx_plain != rx_bip_prev_reg);
    // RQ17 all-ones on fail or defect
    rx_ais     = ssf_sync_reg[1] | defect_reg;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      rx_pos_reg      <= '{row: ROW_FIRST, col: COL_FIRST};
      rx_scr_reg      <= SCR_SEED;
      rx_bip_acc_reg  <= 8'h00;
      rx_bip_prev_reg <= 8'h00;
      o_rx_data       <= 8'h00;
      o_rx_fs         <= 1'b0;
      o_near_end_block_error <= 1'b0;
    end
    else
    begin
      o_near_end_block_error <= 1'b0;
      if (tick)
      begin
        rx_pos_reg <= rx_pos;
        if (!rsoh_unscrambled(rx_pos))
          rx_scr_reg <= rx_step[6:0];
        // RQ13 parity over received bytes
        if (rx_in_reg.fs)
        begin
          rx_bip_prev_reg <= rx_bip_acc_reg;
          rx_bip_acc_reg  <= rx_in_reg.data;
        end
        else
          rx_bip_acc_reg <= rx_bip_acc_reg ^ rx_in_reg.data;
        // RQ14 block error pulse
        o_near_end_block_error <= parity_bad;
        // RQ18 all-ones after descrambling
        // RQ19 applied on next byte
        // RQ23 pass data and marker
        o_rx_data <= rx_ais ? ALL_ONES : rx_plain;
        o_rx_fs   <= rx_in_reg.fs;
      end
    end
  end

  // Errored-frame count; a write clears it, but an error in that cycle counts.
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      err_count_reg <= 16'h0000;
    else if (bus_write && i_avs_address == REG_ERR_COUNT)
      err_count_reg <= {15'h0000, o_near_end_block_error};
    else if (o_near_end_block_error && err_count_reg != 16'hFFFF)
      err_count_reg <= 16'(err_count_reg + 16'h0001);
  end

  // A trace byte is accepted once it repeats in consecutive frames.
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      trace_cand_reg <= TRACE_RESET;
      trace_cnt_reg  <= 2'h0;
      acc_trace_reg  <= TRACE_RESET;
    end
    // RQ15 recover and accept trace
    else if (tick && rx_pos.row == ROW_FIRST && rx_pos.col == COL_TRACE)
    begin
      trace_cand_reg <= rx_in_reg.data;
      if (rx_in_reg.data != trace_cand_reg)
        trace_cnt_reg <= 2'h1;
      else if (trace_cnt_reg != TRACE_PERSIST)
      begin
        trace_cnt_reg <= 2'(trace_cnt_reg + 2'h1);
        if (2'(trace_cnt_reg + 2'h1) == TRACE_PERSIST)
          acc_trace_reg <= rx_in_reg.data;
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      defect_reg              <= 1'b0;
      o_trace_mismatch_report <= 1'b0;
      rx_ais_reg              <= 1'b0;
      o_rx_tsf                <= 1'b0;
    end
    else
    begin
      // RQ16 mismatch defect
      defect_reg <= ~ctrl_reg[CTRL_TIM_DISABLE] & ctrl_reg[CTRL_EXP_MODE]
                    & (acc_trace_reg != exp_trace_reg);
      // RQ20 report gated by monitoring
      o_trace_mismatch_report <= ctrl_reg[CTRL_MONITORED] & defect_reg;
      rx_ais_reg <= rx_ais;
      // RQ17 trail signal fail
      o_rx_tsf   <= rx_ais;
    end
  end

  // Byte clocks out fall just after data change, rise mid-byte.
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_tx_byte_clk <= 1'b0;
      o_rx_byte_clk <= 1'b0;
    end
    else
    begin
      // RQ23 byte clock passed on
      o_tx_byte_clk <= ~link_clk_dly_reg;
      o_rx_byte_clk <= ~link_clk_dly_reg;
    end
  end

endmodule

// File: tb/rsoh_proc_monitor.sv
// Port checker for rsoh_proc: bus handshake, byte clocks and alarms.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module rsoh_proc_monitor
  import rsoh_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rstn,
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_avs_waitrequest,
  input wire logic       i_rx_ssf,
  input wire logic       o_rx_tsf,
  input wire logic [7:0] o_rx_data,
  input wire logic       o_rx_byte_clk,
  input wire logic [7:0] o_tx_data,
  input wire logic       o_tx_fs,
  input wire logic       o_tx_byte_clk,
  input wire logic       o_trace_mismatch_report,
  input wire logic       o_near_end_block_error
);
  logic [5:0] tsf_cnt_reg;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  // Bytes launched before the alarm may stay on the pins for 40 clocks, two and a half byte periods.
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn || !o_rx_tsf)
      tsf_cnt_reg <= 6'h00;
    else if (tsf_cnt_reg != 6'h3F)
      tsf_cnt_reg <= tsf_cnt_reg + 6'h01;
  end

  chk_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("no answer after one wait state");
  chk_wait_low_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  chk_tsf_on_fail: assert property ($rose(i_rx_ssf) |-> ##[1:8] o_rx_tsf)
    else $error("signal fail not passed on");
  chk_report_has_tsf: assert property (o_trace_mismatch_report |-> o_rx_tsf)
    else $error("report without defect");
  chk_rx_all_ones: assert property ($rose(o_rx_byte_clk) && tsf_cnt_reg > 6'h28
    |-> o_rx_data == ALL_ONES) else $error("receive data not all ones");
  chk_tx_frame_start: assert property ($rose(o_tx_byte_clk) && o_tx_fs
    |-> o_tx_data == FRAMING_ONE) else $error("frame start byte wrong");
  chk_rx_clk_period: assert property ($rose(o_rx_byte_clk)
    |=> (!$rose(o_rx_byte_clk)) [*8]) else $error("receive byte clock too fast");
  chk_error_pulse: assert property (o_near_end_block_error
    |=> !o_near_end_block_error) else $error("block error pulse too long");
endmodule

bind rsoh_proc rsoh_proc_monitor u_rsoh_proc_monitor (
  .i_clock, .i_rstn, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_rx_ssf,
  .o_rx_tsf, .o_rx_data, .o_rx_byte_clk, .o_tx_data, .o_tx_fs, .o_tx_byte_clk,
  .o_trace_mismatch_report, .o_near_end_block_error
);

// File: tb/rsoh_link_model.sv
// Far-side link model: free-running byte clock, short frames in both directions.
// Assumes the bench takes o_exp_* whenever o_exp_stb toggles.
`timescale 1ns/1ps
module rsoh_link_model
  import rsoh_pkg::*;
#(
  parameter int FRAME_LEN = 160
)
(
  input  wire logic       i_clock,
  input  wire logic       i_rx_ais,
  input  wire logic       i_tx_force,
  input  wire logic [7:0] i_tx_trace,
  input  wire logic [7:0] i_rx_trace,
  output logic            o_link_clk,
  output rsoh_byte_t      o_tx,
  output rsoh_byte_t      o_rx,
  output logic [8:0]      o_exp_tx,
  output logic [8:0]      o_exp_rx,
  output logic            o_exp_stb
);
  int         col = FRAME_LEN;
  int         seed = 34866;
  int         skip = 0;
  logic [6:0] scr = 7'h7F;
  logic [7:0] mask;
  logic [7:0] pay;
  logic [7:0] plain;
  logic [7:0] etx;
  logic [9:0] mode_q = 10'h000;
  logic [8:0] hold_tx = 9'h000;
  logic [8:0] hold_rx = 9'h000;
  logic       held = 1'b0;

  initial
  begin
    o_link_clk = 1'b0;
    o_tx = '0;
    o_rx = '0;
    o_exp_tx = 9'h000;
    o_exp_rx = 9'h000;
    o_exp_stb = 1'b0;
    #3.3;
    forever #40 o_link_clk = ~o_link_clk;
  end

  // Bytes change one system clock after the link clock falls, away from its rise.
  always @(negedge o_link_clk)
  begin
    @(posedge i_clock);
    col = (col >= FRAME_LEN) ? 1 : col + 1;
    // random content keeps bypassed bytes free of long runs
    pay = 8'($random(seed));
    plain = (col == 97) ? i_rx_trace : pay;
    if (col == 145)
      scr = 7'h7F;
    mask = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      if (col >= 145)
      begin
        mask[i] = scr[6];
        scr = {scr[5:0], scr[6] ^ scr[5]};
      end
    end
    if (col <= 48)
      etx = FRAMING_ONE;
    else if (col <= 96)
      etx = FRAMING_TWO;
    else if (col == 97)
      etx = i_tx_trace;
    else if (col >= 145 && i_tx_force)
      etx = ALL_ONES;
    else
      etx = pay;
    // A mode change lands on the pins somewhere within the next few bytes.
    if ({i_rx_ais, i_tx_force, i_tx_trace} != mode_q)
      skip = 4;
    mode_q = {i_rx_ais, i_tx_force, i_tx_trace};
    o_tx <= '{fs: (col == 1), data: pay};
    o_rx <= '{fs: (col == 1), data: plain ^ mask};
    // Notes go out one byte late, so a mode change that reaches the block while
    // a byte is still in its synchronisers also voids that byte's note.
    o_exp_tx <= {hold_tx[8] && skip == 0, hold_tx[7:0]};
    o_exp_rx <= {hold_rx[8] && skip == 0, hold_rx[7:0]};
    if (held)
      o_exp_stb <= ~o_exp_stb;
    held = 1'b1;
    hold_tx = {skip == 0, etx ^ mask};
    hold_rx = {skip == 0, i_rx_ais ? ALL_ONES : plain};
    if (skip > 0)
      skip--;
  end
endmodule

// File: tb/tb_rsoh_proc.sv
// Bench for rsoh_proc: registers over Avalon-MM, both link directions, alarms.
// Assumes rsoh_link_model on the far side and the bound port checker.
`timescale 1ns/1ps
module tb_rsoh_proc
  import rsoh_pkg::*;
;
  localparam int FRAME_LEN = 160;
  logic        i_clock = 1'b0;
  logic        i_rstn = 1'b0;
  logic [4:0]  i_avs_address = 5'h00;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0]  i_avs_byteenable = 4'hF;
  logic        i_tx_ssf = 1'b0;
  logic        i_rx_ssf = 1'b0;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        i_link_clk;
  logic [7:0]  o_tx_data;
  logic        o_tx_fs;
  logic        o_tx_byte_clk;
  logic [7:0]  o_rx_data;
  logic        o_rx_fs;
  logic        o_rx_byte_clk;
  logic        o_rx_tsf;
  logic        o_trace_mismatch_report;
  rsoh_byte_t  tx_byte;
  rsoh_byte_t  rx_byte;
  logic [8:0]  exp_tx;
  logic [8:0]  exp_rx;
  logic [8:0]  e;
  logic [8:0]  txq[$];
  logic [8:0]  rxq[$];
  logic        exp_stb;
  logic        stb_q = 1'b0;
  logic        tbc_q = 1'b0;
  logic        rbc_q = 1'b0;
  logic        tx_on = 1'b0;
  logic        rx_on = 1'b0;
  logic        rx_ais = 1'b0;
  logic [3:0]  ctrl_m = CTRL_RESET;
  logic [7:0]  tx_trace = 8'h00;
  logic [7:0]  rx_trace = 8'h00;
  logic [31:0] rdata;
  int          seed = 34866;
  int          err_count = 0;
  int          tests_run = 0;
  int          tx_k = 0;
  int          rx_k = 0;
  wire         tx_force = i_tx_ssf & ctrl_m[3];

  rsoh_link_model #(.FRAME_LEN(FRAME_LEN)) u_rsoh_link_model (
    .i_clock, .i_rx_ais(rx_ais), .i_tx_force(tx_force), .i_tx_trace(tx_trace),
    .i_rx_trace(rx_trace), .o_link_clk(i_link_clk), .o_tx(tx_byte), .o_rx(rx_byte),
    .o_exp_tx(exp_tx), .o_exp_rx(exp_rx), .o_exp_stb(exp_stb)
  );

  rsoh_proc u_rsoh_proc (
    .i_clock, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_link_clk,
    .i_tx_data(tx_byte.data), .i_tx_fs(tx_byte.fs), .i_tx_ssf, .o_tx_data, .o_tx_fs,
    .o_tx_byte_clk, .i_rx_data(rx_byte.data), .i_rx_fs(rx_byte.fs), .i_rx_ssf,
    .o_rx_data, .o_rx_fs, .o_rx_byte_clk, .o_rx_tsf, .o_trace_mismatch_report,
    .o_near_end_block_error()
  );

  always #2.5 i_clock = ~i_clock;

  task automatic final_report();
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] seen, input logic [31:0] x);
    tests_run++;
    if (seen !== x)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, x);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= d;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (o_avs_waitrequest !== 1'b0 && n < 20);
    rdata = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (o_avs_waitrequest !== 1'b0)
    begin
      err_count++;
      final_report();
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    cmp(rdata, x);
  endtask

  task automatic frames(input int n);
    repeat (n * FRAME_LEN) @(posedge i_link_clk);
  endtask

  // Notes from the link model are queued; each byte clock rise takes the oldest.
  always @(posedge i_clock)
  begin
    if (exp_stb !== stb_q)
    begin
      txq.push_back(exp_tx);
      rxq.push_back(exp_rx);
    end
    stb_q = exp_stb;
    if (o_tx_byte_clk && !tbc_q && (tx_on || o_tx_fs) && txq.size() > 0)
    begin
      tx_on = 1'b1;
      e = txq.pop_front();
      cmp({31'h0, o_tx_fs}, {31'h0, tx_k == 0});
      tx_k = (tx_k + 1) % FRAME_LEN;
      if (e[8])
        cmp({24'h0, o_tx_data}, {24'h0, e[7:0]});
    end
    if (o_rx_byte_clk && !rbc_q && (rx_on || o_rx_fs) && rxq.size() > 0)
    begin
      rx_on = 1'b1;
      e = rxq.pop_front();
      cmp({31'h0, o_rx_fs}, {31'h0, rx_k == 0});
      rx_k = (rx_k + 1) % FRAME_LEN;
      if (e[8])
        cmp({24'h0, o_rx_data}, {24'h0, e[7:0]});
    end
    tbc_q = o_tx_byte_clk;
    rbc_q = o_rx_byte_clk;
  end

  initial
  begin
    #450000;
    err_count++;
    final_report();
  end

  initial
  begin
    repeat (5) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd_chk(REG_CTRL, {28'h0, CTRL_RESET});
    rd_chk(REG_EXP_TRACE, 32'h0);
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    rd_chk(5'h14, 32'h0);
    // A write with the low byte lane disabled must leave the register alone.
    i_avs_byteenable <= 4'hE;
    bus(1'b1, REG_EXP_TRACE, 32'h000000A5);
    i_avs_byteenable <= 4'hF;
    rd_chk(REG_EXP_TRACE, 32'h0);
    // configured trace on every outgoing frame
    repeat (3)
    begin
      tx_trace = 8'($random(seed));
      bus(1'b1, REG_TX_TRACE, {24'h0, tx_trace});
      rd_chk(REG_TX_TRACE, {24'h0, tx_trace});
      frames(2);
    end
    // payload forced to ones only while the fail input is in use
    i_tx_ssf <= 1'b1;
    frames(2);
    rd_chk(REG_STATUS, 32'h8);
    ctrl_m = 4'h6;
    bus(1'b1, REG_CTRL, 32'h6);
    frames(2);
    rd_chk(REG_STATUS, 32'h0);
    ctrl_m = CTRL_RESET;
    bus(1'b1, REG_CTRL, 32'hE);
    i_tx_ssf <= 1'b0;
    // receive fail forces all ones and signal fail
    i_rx_ssf <= 1'b1;
    rx_ais = 1'b1;
    frames(1);
    cmp({31'h0, o_rx_tsf}, 32'h1);
    i_rx_ssf <= 1'b0;
    rx_ais = 1'b0;
    frames(1);
    cmp({31'h0, o_rx_tsf}, 32'h0);
    // accepted trace, mismatch and its report
    bus(1'b1, REG_CTRL, 32'hF);
    rx_trace = 8'($random(seed)) | 8'h01;
    frames(4);
    rd_chk(REG_STATUS, {16'h0, rx_trace, 8'h00});
    bus(1'b1, REG_CTRL, 32'hE);
    rx_ais = 1'b1;
    frames(1);
    rd_chk(REG_STATUS, {16'h0, rx_trace, 8'h07});
    bus(1'b1, REG_CTRL, 32'hA);
    rd_chk(REG_STATUS, {16'h0, rx_trace, 8'h05});
    cmp({31'h0, o_trace_mismatch_report}, 32'h0);
    bus(1'b1, REG_EXP_TRACE, {24'h0, rx_trace});
    rx_ais = 1'b0;
    bus(1'b1, REG_CTRL, 32'hE);
    frames(1);
    rd_chk(REG_STATUS, {16'h0, rx_trace, 8'h00});
    rd_chk(REG_ERR_COUNT, 32'h0);
    bus(1'b1, REG_ERR_COUNT, 32'h0);
    rd_chk(REG_ERR_COUNT, 32'h0);
    final_report();
  end
endmodule
